/* logic/dsoc_pkg.sv */
// Shared constants of the deserializer output and control block.
// Assumes one 20 MHz clock and one bit per lane per clock.

// ****************************************************
// Constants and types
// ****************************************************
package dsoc_pkg;
    localparam int         LANES      = 2;      // Serial lanes
    localparam int         WORD_W     = 32;     // Parallel word width
    localparam int         HALF_W     = 16;     // Data bits per lane frame
    localparam int         FRAME_BITS = 18;     // Clock pair plus data
    localparam int         CLK_BITS   = 2;      // Embedded clock bits
    localparam logic [1:0] CLK_PAT    = 2'h2;   // Embedded one then zero
    localparam int         POS_W      = 5;      // Bit position counter
    localparam logic [4:0] POS_RISE   = 5'h00;  // Recovered clock rises
    localparam logic [4:0] POS_FALL   = 5'h09;  // Recovered clock falls
    localparam logic [4:0] POS_LAST   = 5'h11;  // Last bit of a frame
    localparam logic [4:0] POS_ONE    = 5'h01;
    localparam logic [2:0] LOCK_GOOD  = 3'h4;   // Good frames to lock
    localparam logic [2:0] GOOD_ONE   = 3'h1;
    localparam logic [1:0] LOSS_BAD   = 2'h2;   // Bad frames to drop lock
    localparam logic [1:0] BAD_ONE    = 2'h1;
    localparam int         ADDR_W     = 8;
    localparam int         DATA_W     = 32;
    // Register byte offsets
    localparam logic [7:0] REG_CTRL     = 8'h00;
    localparam logic [7:0] REG_STATUS   = 8'h04;
    localparam logic [7:0] REG_IRQ_STAT = 8'h08;
    localparam logic [7:0] REG_IRQ_MASK = 8'h0c;
    localparam logic [7:0] REG_WORD_CNT = 8'h10;
    // Field positions
    localparam int CTRL_RELOCK = 0;
    localparam int IRQ_W       = 3;
    localparam logic [2:0] MASK_RST = 3'h0;
    localparam int STS_LOCK  = 0;
    localparam int STS_OE    = 1;
    localparam int STS_PWR   = 2;
    localparam int STS_EN    = 3;
    localparam int STS_EDGE  = 4;
    localparam int STS_TIE   = 5;
    localparam int STS_STATE = 6;
    typedef enum logic [1:0] {
        ST_PDOWN  = 2'h0,
        ST_HUNT   = 2'h1,
        ST_VERIFY = 2'h2,
        ST_LOCKED = 2'h3
    } dsoc_state_e;
endpackage : dsoc_pkg

/* logic/dsoc_lane_if.sv */
// Link between the control core and one lane deframer.
// Assumes both ends run on the same clock.
interface dsoc_lane_if;
    import dsoc_pkg::*;
    logic              ser_bit;    // Lane bit this cycle
    logic              frame_end;  // Last bit of frame now
    logic [HALF_W-1:0] half_word;  // Captured data half
    logic              clk_ok;     // Clock pair was found
    modport ctrl (output ser_bit, output frame_end,
                  input half_word, input clk_ok);
    modport lane (input ser_bit, input frame_end,
                  output half_word, output clk_ok);
endinterface : dsoc_lane_if

/* logic/dsoc_lane.sv */
// Per-lane deframer: shifts one bit per clock and splits
// each frame into clock pair and data half.
// Assumes the core marks frame ends.
module dsoc_lane (
    input  wire logic  mclk_i,
    input  wire logic  rstn_i,
    dsoc_lane_if.lane  lif
);
    import dsoc_pkg::*;

    logic [FRAME_BITS-1:0] shift_r;   // Newest bit at the bottom
    logic [FRAME_BITS-1:0] shift_nxt;

    // Include this cycle's bit so the frame is whole at its end
    always_comb begin
        shift_nxt = {shift_r[FRAME_BITS-2:0], lif.ser_bit};
    end

    // Free-running shifter
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            shift_r <= '0;
        end else begin
            shift_r <= shift_nxt;
        end
    end

    // Capture data and check the embedded clock pair
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            lif.half_word <= '0;
            lif.clk_ok    <= 1'b0;
        end else if (lif.frame_end) begin
            lif.half_word <= shift_nxt[HALF_W-1:0];
            lif.clk_ok    <= (shift_nxt[FRAME_BITS-1 -: CLK_BITS] == CLK_PAT);
        end
    end
endmodule : dsoc_lane

/* logic/dsoc_core.sv */
// Deserializer output and control: lock tracking,
// recovered word clock, parallel output and registers.
// Assumes lane bits and pins synchronous to mclk_i.
//
// Local design decisions: the register addresses and strobed register access.
module dsoc_core (
    input  wire logic                        mclk_i,
    input  wire logic                        rstn_i,
    input  wire logic [dsoc_pkg::LANES-1:0]  serial_lane_in_i,
    input  wire logic                        strobe_edge_select_i,
    input  wire logic                        out_en_i,
    input  wire logic                        powerdown_n_i,
    input  wire logic                        tie_low_input_i,
    input  wire logic [dsoc_pkg::ADDR_W-1:0] reg_addr_i,
    input  wire logic [dsoc_pkg::DATA_W-1:0] reg_wdata_i,
    input  wire logic                        reg_wr_i,
    input  wire logic                        reg_rd_i,
    output logic      [dsoc_pkg::DATA_W-1:0] reg_rdata_o,
    output logic                             irq_o,
    output logic      [dsoc_pkg::WORD_W-1:0] par_word_out_o,
    output logic                             par_word_oe_o,
    output logic                             recovered_word_clk_o,
    output logic                             recovered_word_clk_oe_o,
    output logic                             lock_o,
    output logic                             lock_oe_o
);
    import dsoc_pkg::*;

    // ************************************************
    // Declarations
    // ************************************************
    dsoc_state_e       state_r;     // Lock state
    dsoc_state_e       state_nxt;
    logic [POS_W-1:0]  pos_r;       // Bit within frame
    logic [POS_W-1:0]  pos_nxt;
    logic [2:0]        good_r;      // Good frames seen
    logic [2:0]        good_nxt;
    logic [1:0]        bad_r;       // Bad frames in a row
    logic [1:0]        bad_nxt;
    logic              slip_r;      // Hold position once
    logic              slip_nxt;
    logic              chk_r;       // Lane results valid
    logic              frame_end;
    logic              relock;      // Software relock
    logic              all_ok;
    logic [LANES-1:0]  lane_ok;
    logic [WORD_W-1:0] rx_word;     // Word from lanes
    logic [WORD_W-1:0] pend_r;      // Word awaiting launch
    logic              pend_v_r;
    logic              launch;
    logic              ev_acq;
    logic              ev_lost;
    logic              ev_ferr;
    logic [IRQ_W-1:0]  stat_r;      // Sticky events
    logic [IRQ_W-1:0]  stat_nxt;
    logic [IRQ_W-1:0]  mask_r;
    logic [IRQ_W-1:0]  w1c;
    logic [DATA_W-1:0] cnt_r;       // Words launched
    logic [DATA_W-1:0] status;

    // ************************************************
    // Lane deframers
    // ************************************************
    // Lane 0 carries the upper half, most significant first
    for (genvar g = 0; g < LANES; g++) begin : g_lane
        dsoc_lane_if lif ();
        assign lif.ser_bit   = serial_lane_in_i[g];
        assign lif.frame_end = frame_end;
        dsoc_lane u_lane (
            .mclk_i (mclk_i),
            .rstn_i (rstn_i),
            .lif    (lif.lane)
        );
        assign lane_ok[g] = lif.clk_ok;
        assign rx_word[WORD_W-1-g*HALF_W -: HALF_W] = lif.half_word;
    end

    assign all_ok = &lane_ok;

    // ************************************************
    // Frame timing
    // ************************************************
    // Position counter; a slip stretches one frame by a bit
    always_comb begin
        if (state_r == ST_PDOWN) begin
            pos_nxt = POS_RISE;
        end else if (slip_r) begin
            pos_nxt = pos_r;
        end else if (pos_r == POS_LAST) begin
            pos_nxt = POS_RISE;
        end else begin
            pos_nxt = pos_r + POS_ONE;
        end
    end

    assign frame_end = (state_r != ST_PDOWN) && !slip_r && (pos_r == POS_LAST);

    // Position and check strobe
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pos_r <= POS_RISE;
            chk_r <= 1'b0;
        end else begin
            pos_r <= pos_nxt;
            chk_r <= frame_end;
        end
    end

    assign relock = reg_wr_i && (reg_addr_i == REG_CTRL) && reg_wdata_i[CTRL_RELOCK];

    // ************************************************
    // Lock state machine
    // ************************************************
    // Lock comes from clock pairs in ordinary frames only;
    // random data may mimic a pair, so several in a row count
    always_comb begin
        state_nxt = state_r;
        good_nxt  = good_r;
        bad_nxt   = bad_r;
        slip_nxt  = 1'b0;
        ev_acq    = 1'b0;
        ev_lost   = 1'b0;
        ev_ferr   = 1'b0;
        if (!powerdown_n_i) begin
            // Standby shuts the loop down
            state_nxt = ST_PDOWN;
            good_nxt  = '0;
            bad_nxt   = '0;
            ev_lost   = (state_r == ST_LOCKED);
        end else if (relock) begin
            state_nxt = ST_HUNT;
            good_nxt  = '0;
            bad_nxt   = '0;
            ev_lost   = (state_r == ST_LOCKED);
        end else begin
            case (state_r)
                ST_PDOWN: begin
                    state_nxt = ST_HUNT;
                end
                ST_HUNT: begin
                    if (chk_r && all_ok) begin
                        state_nxt = ST_VERIFY;
                        good_nxt  = GOOD_ONE;
                    end else if (chk_r) begin
                        slip_nxt = 1'b1; // Try next bit
                    end
                end
                ST_VERIFY: begin
                    if (chk_r && all_ok) begin
                        good_nxt = good_r + GOOD_ONE;
                        if (good_r + GOOD_ONE == LOCK_GOOD) begin
                            state_nxt = ST_LOCKED;
                            ev_acq    = 1'b1;
                        end
                    end else if (chk_r) begin
                        state_nxt = ST_HUNT;
                        good_nxt  = '0;
                        slip_nxt  = 1'b1;
                    end
                end
                ST_LOCKED: begin
                    if (chk_r && all_ok) begin
                        bad_nxt = '0;
                    end else if (chk_r) begin
                        ev_ferr = 1'b1;
                        bad_nxt = bad_r + BAD_ONE;
                        if (bad_r + BAD_ONE == LOSS_BAD) begin
                            // Drop lock and hunt again
                            state_nxt = ST_HUNT;
                            bad_nxt   = '0;
                            good_nxt  = '0;
                            slip_nxt  = 1'b1;
                            ev_lost   = 1'b1;
                        end
                    end
                end
                default: begin
                    state_nxt = ST_PDOWN;
                end
            endcase
        end
    end

    // State and counters
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_r <= ST_PDOWN;
            good_r  <= '0;
            bad_r   <= '0;
            slip_r  <= 1'b0;
        end else begin
            state_r <= state_nxt;
            good_r  <= good_nxt;
            bad_r   <= bad_nxt;
            slip_r  <= slip_nxt;
        end
    end

    // ************************************************
    // Word path
    // ************************************************
    // Launch on the selected edge of the recovered clock
    assign launch = (state_r == ST_LOCKED) && pend_v_r && (pos_nxt != pos_r) &&
                    (strobe_edge_select_i ? (pos_nxt == POS_RISE) : (pos_nxt == POS_FALL));

    // One pending word per frame keeps the order intact
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pend_r   <= '0;
            pend_v_r <= 1'b0;
        end else if (state_r != ST_LOCKED) begin
            pend_v_r <= 1'b0;
        end else if (chk_r && all_ok) begin
            pend_r   <= rx_word;
            pend_v_r <= 1'b1;
        end else if (launch) begin
            pend_v_r <= 1'b0;
        end
    end

    // Output word and launch count
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            par_word_out_o <= '0;
            cnt_r          <= '0;
        end else if (launch) begin
            par_word_out_o <= pend_r;
            cnt_r          <= cnt_r + 32'h0000_0001;
        end
    end

    // Recovered clock: high first half of each frame
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            recovered_word_clk_o <= 1'b0;
        end else begin
            recovered_word_clk_o <= (state_nxt != ST_PDOWN) && (pos_nxt < POS_FALL);
        end
    end

    // ************************************************
    // Pin drive enables
    // ************************************************
    // Enable low only floats pins; the loop keeps running
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            par_word_oe_o           <= 1'b0;
            recovered_word_clk_oe_o <= 1'b0;
            lock_o                  <= 1'b0;
            lock_oe_o               <= 1'b0;
        end else begin
            par_word_oe_o           <= (state_r == ST_LOCKED) && powerdown_n_i && out_en_i;
            recovered_word_clk_oe_o <= (state_r == ST_LOCKED) && powerdown_n_i && out_en_i;
            lock_o                  <= (state_r == ST_LOCKED) && powerdown_n_i;
            lock_oe_o               <= powerdown_n_i;
        end
    end

    // ************************************************
    // Interrupts
    // ************************************************
    // A set in the clearing cycle wins over the clear
    always_comb begin
        w1c = '0;
        if (reg_wr_i && (reg_addr_i == REG_IRQ_STAT)) begin
            w1c = reg_wdata_i[IRQ_W-1:0];
        end
        stat_nxt = (stat_r & ~w1c) | {ev_ferr, ev_lost, ev_acq};
    end

    // Sticky status, mask and interrupt level
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            stat_r <= '0;
            mask_r <= MASK_RST;
            irq_o  <= 1'b0;
        end else begin
            stat_r <= stat_nxt;
            if (reg_wr_i && (reg_addr_i == REG_IRQ_MASK)) begin
                mask_r <= reg_wdata_i[IRQ_W-1:0];
            end
            irq_o <= |(stat_nxt & mask_r);
        end
    end

    // ************************************************
    // Register reads
    // ************************************************
    always_comb begin
        status                = '0;
        status[STS_LOCK]      = (state_r == ST_LOCKED);
        status[STS_OE]        = par_word_oe_o;
        status[STS_PWR]       = powerdown_n_i;
        status[STS_EN]        = out_en_i;
        status[STS_EDGE]      = strobe_edge_select_i;
        status[STS_TIE]       = tie_low_input_i;
        status[STS_STATE+1 -: 2] = state_r;
    end

    // Read data stands one cycle after the strobe only
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            reg_rdata_o <= '0;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                REG_STATUS:   reg_rdata_o <= status;
                REG_IRQ_STAT: reg_rdata_o <= {{(DATA_W-IRQ_W){1'b0}}, stat_r};
                REG_IRQ_MASK: reg_rdata_o <= {{(DATA_W-IRQ_W){1'b0}}, mask_r};
                REG_WORD_CNT: reg_rdata_o <= cnt_r;
                default:      reg_rdata_o <= '0;
            endcase
        end else begin
            reg_rdata_o <= '0;
        end
    end

    // ************************************************
    // Checks
    // ************************************************
    default clocking dsoc_cb @(posedge mclk_i);
    endclocking
    default disable iff (!rstn_i);

    unlock_float_a :
        assert property (state_r != ST_LOCKED |=> !par_word_oe_o && !recovered_word_clk_oe_o && !lock_o)
        else $error("Outputs driven while unlocked");

    lock_flag_a :
        assert property (state_r == ST_LOCKED && powerdown_n_i |=> lock_o && lock_oe_o)
        else $error("Lock flag low while locked");

    rise_launch_a :
        assert property ($changed(par_word_out_o) && $past(strobe_edge_select_i)
                         |-> $rose(recovered_word_clk_o))
        else $error("Word not launched on rising edge");

    fall_launch_a :
        assert property ($changed(par_word_out_o) && !$past(strobe_edge_select_i)
                         |-> $fell(recovered_word_clk_o))
        else $error("Word not launched on falling edge");

    en_float_a :
        assert property (!out_en_i |=> !par_word_oe_o && !recovered_word_clk_oe_o)
        else $error("Outputs driven while disabled");

    en_keep_lock_a :
        assert property (!out_en_i && state_r == ST_LOCKED && powerdown_n_i && !relock && !chk_r
                         |=> lock_o && state_r == ST_LOCKED)
        else $error("Lock lost by output disable");

    pdown_float_a :
        assert property (!powerdown_n_i |=> state_r == ST_PDOWN && !lock_oe_o && !par_word_oe_o
                         && !recovered_word_clk_oe_o)
        else $error("Standby did not float pins");

    lock_count_a :
        assert property (state_r == ST_VERIFY && chk_r && all_ok && good_r == LOCK_GOOD - GOOD_ONE
                         && powerdown_n_i && !relock |=> state_r == ST_LOCKED ##1 (lock_o || !$past(powerdown_n_i)))
        else $error("Lock not taken after good frames");

    clk_rise_a :
        assert property ($rose(recovered_word_clk_o) |-> pos_r == POS_RISE)
        else $error("Recovered clock out of frame phase");

    word_hold_a :
        assert property ($changed(par_word_out_o) |=> $stable(par_word_out_o)[*8])
        else $error("Word not stable around strobe");

    lock_seen_c : cover property ($rose(lock_o));
    lock_drop_c : cover property ($fell(lock_o) && powerdown_n_i);
    fall_word_c : cover property ($changed(par_word_out_o) && !strobe_edge_select_i);
    pdown_c     : cover property (lock_o ##1 !powerdown_n_i);
endmodule : dsoc_core

/* dv/dsoc_ser_model.sv */
// Behavioural serializer feeding the two lanes of the receiver.
// Assumes the receiver samples one bit per lane on each mclk_i rise.
module dsoc_ser_model (
    input  wire logic                        mclk_i,
    input  wire logic                        rstn_i,
    input  wire logic [dsoc_pkg::WORD_W-1:0] word_i,   // Next word to send
    input  wire logic                        bad_i,    // Corrupt clock pair
    output logic                             take_o,   // Word taken at next rise
    output logic      [dsoc_pkg::LANES-1:0]  lane_o    // Serial bits
);
    timeunit 1ns;
    timeprecision 1ns;
    import dsoc_pkg::*;
    logic [4:0]        pos_r;  // Bit position in frame
    logic [WORD_W-1:0] wd_r;   // Word in flight
    logic              bad_r;  // Frame carries a broken clock pair

    // Frames run back to back; a real link never idles the stream
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pos_r <= 5'h00;
            wd_r  <= 32'h0;
            bad_r <= 1'b0;
        end else if (pos_r == 5'h11) begin
            pos_r <= 5'h00;
            wd_r  <= word_i;
            bad_r <= bad_i;
        end else begin
            pos_r <= pos_r + 5'h01;
        end
    end

    assign take_o = (pos_r == 5'h11);

    // Clock pair one-zero, then data MSB first; lane 0 carries the upper half
    always_comb begin
        for (int l = 0; l < LANES; l++) begin
            if (pos_r == 5'h00)
                lane_o[l] = 1'b1;
            else if (pos_r == 5'h01)
                lane_o[l] = bad_r;  // Only broken when the bench asks
            else
                lane_o[l] = wd_r[31 - 16 * l - (int'(pos_r) - 2)];
        end
    end
endmodule : dsoc_ser_model

/* dv/deser_output_control_test.sv */
// Self-checking bench of the receiver output and control block.
// Assumes the serializer model in the same folder.
module deser_output_control_test;
    timeunit 1ns;
    timeprecision 1ns;
    import dsoc_pkg::*;
    logic        mclk_i = 1'b0;
    logic        rstn_i = 1'b0;
    logic [1:0]  lanes;
    logic        sel = 1'b1, en = 1'b1, pdn = 1'b1, bad = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0, word = 32'h0, rdata, pw, exp_w;
    logic        wr = 1'b0, rd_s = 1'b0, irq_o, oe, rck, rck_oe, lock_o, lock_oe, take;
    logic [31:0] seed = 32'h1d74f2ff;
    logic [31:0] exp_q[$];  // Words sent, oldest first
    logic        clk_q, synced, nxt_w;
    logic [31:0] w_q;
    int          err_count = 0, cmp_count = 0, per, cyc = 0;

    always #25 mclk_i = ~mclk_i;

    dsoc_ser_model u_dsoc_ser_model (.mclk_i(mclk_i), .rstn_i(rstn_i), .word_i(word), .bad_i(bad),
        .take_o(take), .lane_o(lanes));
    dsoc_core u_dsoc_core (.mclk_i(mclk_i), .rstn_i(rstn_i), .serial_lane_in_i(lanes),
        .strobe_edge_select_i(sel), .out_en_i(en), .powerdown_n_i(pdn),
        .tie_low_input_i(1'b0),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd_s),
        .reg_rdata_o(rdata), .irq_o(irq_o), .par_word_out_o(pw), .par_word_oe_o(oe),
        .recovered_word_clk_o(rck), .recovered_word_clk_oe_o(rck_oe), .lock_o(lock_o),
        .lock_oe_o(lock_oe));

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    task chk(input string n, input logic [31:0] seen, input logic [31:0] e);
        cmp_count++;
        if (seen !== e) begin
            err_count++;
            $display("Error %s expected %h seen %h", n, e, seen);
        end
    endtask : chk

    task final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : final_report

    // Register bus cycles: one-cycle strobes, read data in the next cycle only
    task wrr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        addr <= a; wdata <= d; wr <= 1'b1;
        @(posedge mclk_i);
        wr <= 1'b0;
    endtask : wrr

    task rdr(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string n);
        @(posedge mclk_i);
        addr <= a; rd_s <= 1'b1;
        @(posedge mclk_i);
        rd_s <= 1'b0;
        @(negedge mclk_i);
        chk(n, rdata & m, e);
    endtask : rdr

    // Bounded wait on the lock flag; relock may need several slipped frames
    task wlock(input logic v);
        for (int i = 0; i < 1500 && lock_o !== v; i++)
            @(negedge mclk_i);
    endtask : wlock

    task wcyc(input int n);
        repeat (n) @(negedge mclk_i);
    endtask : wcyc

    // ****************************************************
    // Driver side: note each word as the serializer takes it
    // ****************************************************
    always @(negedge mclk_i) begin
        nxt_w = take && rstn_i;
        if (nxt_w)
            exp_q.push_back(word);
    end
    always @(posedge mclk_i) if (nxt_w) word <= xs();

    // ****************************************************
    // Watcher: compare each launched word against the oldest note
    // ****************************************************
    always @(negedge mclk_i) begin
        if (!rstn_i || oe !== 1'b1) begin
            synced = 1'b0;
            per = 0;
        end else begin
            per++;
            // Right after lock the first edge still shows a stale word; sync on a real launch
            if (rck !== clk_q && rck === sel && (synced || pw !== w_q)) begin
                // Words sent while unlocked are never shown; skip to the first shown
                if (!synced)
                    while (exp_q.size() > 1 && exp_q[0] !== pw) void'(exp_q.pop_front());
                else
                    chk("period", 32'(per), 32'd18);
                exp_w = exp_q.pop_front();
                chk("word", pw, exp_w);
                synced = 1'b1;
                per = 0;
            end else if (synced && pw !== w_q) begin
                chk("stable", pw, w_q);
            end
        end
        clk_q = rck;
        w_q = pw;
    end

    // Hang guard, well above the longest expected run
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 40000) begin
            err_count++;
            final_report();
        end
    end

    initial begin
        repeat (5) @(posedge mclk_i);
        rstn_i <= 1'b1;
        wcyc(3);
        chk("lock low", {lock_oe, lock_o, oe, rck_oe}, 32'h8);
        rdr(REG_IRQ_MASK, 32'hffffffff, 32'h0, "mask rst");
        rdr(8'h14, 32'hffffffff, 32'h0, "unmapped");
        $display("test reset done");
        wlock(1'b1);
        chk("lock", {lock_o, lock_oe}, 32'h3);
        rdr(REG_STATUS, 32'hff, 32'hdf, "status");
        chk("irq masked", irq_o, 1'b0);
        wrr(REG_IRQ_MASK, 32'h7);
        wcyc(2);
        chk("irq", irq_o, 1'b1);
        wrr(REG_IRQ_STAT, 32'h1);
        wcyc(2);
        chk("irq clr", irq_o, 1'b0);
        $display("test lock done");
        wcyc(200);
        chk("rising", synced, 1'b1);
        $display("test rising done");
        @(posedge mclk_i);
        en <= 1'b0;
        wcyc(3);
        chk("en off", {oe, rck_oe, lock_o}, 32'h1);
        @(posedge mclk_i);
        sel <= 1'b0;
        wcyc(40);
        @(posedge mclk_i);
        en <= 1'b1;
        wcyc(200);
        chk("falling", synced, 1'b1);
        $display("test falling done");
        @(posedge mclk_i);
        en <= 1'b0;
        bad <= 1'b1;
        wlock(1'b0);
        chk("lost", lock_o, 1'b0);
        @(posedge mclk_i);
        bad <= 1'b0;
        en <= 1'b1;
        wcyc(3);
        chk("unlocked", {oe, rck_oe}, 32'h0);
        rdr(REG_IRQ_STAT, 32'h6, 32'h6, "loss evt");
        wrr(REG_IRQ_STAT, 32'h7);
        wlock(1'b1);
        wcyc(100);
        $display("test loss done");
        @(posedge mclk_i);
        pdn <= 1'b0;
        wcyc(3);
        chk("standby", {lock_oe, lock_o, oe, rck_oe}, 32'h0);
        rdr(REG_STATUS, 32'hc7, 32'h0, "status pd");
        @(posedge mclk_i);
        pdn <= 1'b1;
        wlock(1'b1);
        wcyc(100);
        chk("relock", {lock_o, synced}, 32'h3);
        $display("test standby done");
        wrr(REG_CTRL, 32'h1);
        wlock(1'b0);
        chk("forced", lock_o, 1'b0);
        wlock(1'b1);
        wcyc(100);
        chk("ctrl relock", {lock_o, synced}, 32'h3);
        $display("test relock done");
        final_report();
    end
endmodule : deser_output_control_test
